// file: dhs_pkg.sv
// constants shared by the tone transceiver sequencer block
package dhs_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int BURST_MS = 50;
   localparam int READY_MS = 100;
   localparam int READY_EXT_MS = 200;
   localparam logic [7:0] PHASE_MS = 8'(BURST_MS);
   localparam logic [7:0] PHASE_EXT_MS = 8'(READY_EXT_MS / 2);
   localparam logic [4:0] OFS_TX_DATA = 5'h00;
   localparam logic [4:0] OFS_RX_DATA = 5'h04;
   localparam logic [4:0] OFS_CONTROL = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0C;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
   localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;
   localparam int CA_TONE_EN = 0;
   localparam int CA_PROGRESS = 1;
   localparam int CA_IRQ_EN = 2;
   localparam int CA_SELECT_B = 3;
   localparam int CB_BURST_N = 0;
   localparam int CB_TEST = 1;
   localparam int CB_SINGLE = 2;
   localparam int CB_COLUMN = 3;
   localparam int ST_IRQ = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_STEER = 3;
   localparam int EV_TX_READY = 0;
   localparam int EV_RX_FULL = 1;
   localparam logic [3:0] CTRL_A_RST = 4'h0;
   localparam logic [3:0] CTRL_B_RST = 4'h0;
   localparam logic [3:0] CODE_RST = 4'h0;
   localparam logic [1:0] EV_RST = 2'h0;
   typedef enum logic [2:0]
   {
      TX_IDLE = 3'b001,
      TX_BURST = 3'b010,
      TX_PAUSE = 3'b100
   } dhs_tx_state_type;
endpackage : dhs_pkg

// file: dhs_sequencer.sv
// tone transceiver control core: registers, burst timer, flags and interrupt pin
`timescale 1ns/1ps
module dhs_sequencer
   import dhs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // receiver side, same clock
   input wire logic rx_valid,
   input wire logic [3:0] rx_code,
   input wire logic steering_delayed,
   // call progress comparator pin
   input wire logic progress_tone_in,
   // transmitter side
   output logic tone_on,
   output logic [3:0] tone_code,
   output logic tone_single,
   output logic tone_column,
   // interrupts
   output logic interrupt_or_progress_out_n,
   output logic irq
);

   logic waitrequest_r, waitrequest_nxt;
   logic [31:0] readdata_r, readdata_nxt;
   logic [3:0] ctrl_a_r, ctrl_a_nxt;
   logic [3:0] ctrl_b_r, ctrl_b_nxt;
   logic second_control_select_r, second_control_select_nxt;
   logic [3:0] tx_code_r, tx_code_nxt;
   logic [3:0] rx_code_r, rx_code_nxt;
   logic tx_empty_r, tx_empty_nxt;
   logic rx_full_r, rx_full_nxt;
   logic [1:0] ev_stat_r, ev_stat_nxt;
   logic [1:0] ev_en_r, ev_en_nxt;
   logic irq_r, irq_nxt;
   logic pin_r, pin_nxt;
   logic tone_on_r, tone_on_nxt;
   dhs_tx_state_type state_r, state_nxt;
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic tick_r, tick_nxt;
   logic [7:0] ms_cnt_r, ms_cnt_nxt;
   logic [2:0] cp_sync_r;
   logic cp_level_r, cp_level_nxt;
   logic wr_done, rd_done, tx_wr, status_rd, ready_evt, rx_evt, burst_mode;
   logic [7:0] phase_len;

   // bus handshake: one wait cycle, then completion
   assign wr_done = write && !waitrequest_r;
   assign rd_done = read && !waitrequest_r;
   assign tx_wr = wr_done && (address == OFS_TX_DATA);
   assign status_rd = rd_done && (address == OFS_STATUS);
   assign burst_mode = !ctrl_b_r[CB_BURST_N];
   // call progress doubles both the burst and the pause
   assign phase_len = ctrl_a_r[CA_PROGRESS] ? PHASE_EXT_MS : PHASE_MS;
   assign rx_evt = rx_valid;

   always_comb
   begin
      waitrequest_nxt = !((read || write) && waitrequest_r);
      readdata_nxt = readdata_r;
      if ((read || write) && waitrequest_r)
      begin
         case (address)
            OFS_TX_DATA: readdata_nxt = {28'h000_0000, tx_code_r};
            OFS_RX_DATA: readdata_nxt = {28'h000_0000, rx_code_r};
            OFS_CONTROL: readdata_nxt = {24'h00_0000, ctrl_b_r, ctrl_a_r};
            OFS_STATUS: readdata_nxt = {28'h000_0000, steering_delayed, rx_full_r,
                                        tx_empty_r, tx_empty_r || rx_full_r};
            OFS_IRQ_STATUS: readdata_nxt = {30'h0000_0000, ev_stat_r};
            OFS_IRQ_ENABLE: readdata_nxt = {30'h0000_0000, ev_en_r};
            default: readdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h0000_0000;
      end
      else
      begin
         waitrequest_r <= waitrequest_nxt;
         readdata_r <= readdata_nxt;
      end
   end

   // control registers and software event registers
   always_comb
   begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      second_control_select_nxt = second_control_select_r;
      tx_code_nxt = tx_code_r;
      ev_en_nxt = ev_en_r;
      if (wr_done && address == OFS_CONTROL)
      begin
         // select is one-shot: the write after control B returns to control A
         if (second_control_select_r)
         begin
            ctrl_b_nxt = writedata[3:0];
            second_control_select_nxt = 1'b0;
         end
         else
         begin
            ctrl_a_nxt = writedata[3:0];
            second_control_select_nxt = writedata[CA_SELECT_B];
         end
      end
      if (tx_wr)
      begin
         tx_code_nxt = writedata[3:0];
      end
      if (wr_done && address == OFS_IRQ_ENABLE)
      begin
         ev_en_nxt = writedata[1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_a_r <= CTRL_A_RST;
         ctrl_b_r <= CTRL_B_RST;
         second_control_select_r <= 1'b0;
         tx_code_r <= CODE_RST;
         ev_en_r <= EV_RST;
      end
      else
      begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         second_control_select_r <= second_control_select_nxt;
         tx_code_r <= tx_code_nxt;
         ev_en_r <= ev_en_nxt;
      end
   end

   // millisecond tick and burst/pause sequencer
   always_comb
   begin
      tick_nxt = 1'b0;
      tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
      if (tick_cnt_r == 32'(TICK_CYCLES - 1))
      begin
         tick_cnt_nxt = 32'h0000_0000;
         tick_nxt = 1'b1;
      end
      state_nxt = state_r;
      ms_cnt_nxt = ms_cnt_r;
      ready_evt = 1'b0;
      tone_on_nxt = 1'b0;
      case (state_r)
         TX_IDLE:
         begin
            // free-running tone in non-burst mode
            tone_on_nxt = !burst_mode && ctrl_a_r[CA_TONE_EN];
         end
         TX_BURST:
         begin
            tone_on_nxt = ctrl_a_r[CA_TONE_EN];
            if (tick_r)
            begin
               ms_cnt_nxt = ms_cnt_r + 8'h01;
               if (ms_cnt_r + 8'h01 >= phase_len)
               begin
                  ms_cnt_nxt = 8'h00;
                  state_nxt = TX_PAUSE;
                  tone_on_nxt = 1'b0;
               end
            end
         end
         TX_PAUSE:
         begin
            if (tick_r)
            begin
               ms_cnt_nxt = ms_cnt_r + 8'h01;
               if (ms_cnt_r + 8'h01 >= phase_len)
               begin
                  ms_cnt_nxt = 8'h00;
                  state_nxt = TX_IDLE;
                  ready_evt = 1'b1;
               end
            end
         end
         default:
         begin
            state_nxt = TX_IDLE;
         end
      endcase
      // a new digit restarts the burst; tick phase restarts so timing is whole ms
      if (tx_wr && burst_mode)
      begin
         state_nxt = TX_BURST;
         ms_cnt_nxt = 8'h00;
         tick_cnt_nxt = 32'h0000_0000;
         tick_nxt = 1'b0;
         tone_on_nxt = ctrl_a_r[CA_TONE_EN];
         ready_evt = 1'b0;
      end
      if (!burst_mode && state_r != TX_IDLE)
      begin
         state_nxt = TX_IDLE;
         ms_cnt_nxt = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= TX_IDLE;
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
         ms_cnt_r <= 8'h00;
         tone_on_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         tick_r <= tick_nxt;
         ms_cnt_r <= ms_cnt_nxt;
         tone_on_r <= tone_on_nxt;
      end
   end

   // flags: a set beats a clear; a read clears only what its data reported
   always_comb
   begin
      tx_empty_nxt = tx_empty_r;
      rx_full_nxt = rx_full_r;
      rx_code_nxt = rx_code_r;
      ev_stat_nxt = ev_stat_r;
      if ((status_rd && readdata_r[ST_TX_EMPTY]) || !burst_mode || tx_wr)
      begin
         tx_empty_nxt = 1'b0;
      end
      if (ready_evt)
      begin
         tx_empty_nxt = 1'b1;
      end
      if (status_rd && readdata_r[ST_RX_FULL])
      begin
         rx_full_nxt = 1'b0;
      end
      if (rx_evt)
      begin
         rx_full_nxt = 1'b1;
         rx_code_nxt = rx_code;
      end
      if (wr_done && address == OFS_IRQ_CLEAR)
      begin
         ev_stat_nxt = ev_stat_r & ~writedata[1:0];
      end
      if (ready_evt)
      begin
         ev_stat_nxt[EV_TX_READY] = 1'b1;
      end
      if (rx_evt)
      begin
         ev_stat_nxt[EV_RX_FULL] = 1'b1;
      end
      irq_nxt = |(ev_stat_nxt & ev_en_nxt);
      // progress mode shows the filter output, test mode the inverted steering
      if (ctrl_a_r[CA_PROGRESS])
      begin
         pin_nxt = cp_level_r;
      end
      else if (ctrl_b_r[CB_TEST])
      begin
         pin_nxt = !steering_delayed;
      end
      else
      begin
         pin_nxt = !(ctrl_a_r[CA_IRQ_EN] && (tx_empty_nxt || rx_full_nxt));
      end
      // pin change counts only when the second and third stages agree
      cp_level_nxt = (cp_sync_r[1] == cp_sync_r[2]) ? cp_sync_r[2] : cp_level_r;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx_empty_r <= 1'b0;
         rx_full_r <= 1'b0;
         rx_code_r <= CODE_RST;
         ev_stat_r <= EV_RST;
         irq_r <= 1'b0;
         pin_r <= 1'b1;
         cp_sync_r <= 3'h0;
         cp_level_r <= 1'b0;
      end
      else
      begin
         tx_empty_r <= tx_empty_nxt;
         rx_full_r <= rx_full_nxt;
         rx_code_r <= rx_code_nxt;
         ev_stat_r <= ev_stat_nxt;
         irq_r <= irq_nxt;
         pin_r <= pin_nxt;
         cp_sync_r <= {cp_sync_r[1:0], progress_tone_in};
         cp_level_r <= cp_level_nxt;
      end
   end

   assign readdata = readdata_r;
   assign waitrequest = waitrequest_r;
   assign tone_on = tone_on_r;
   assign tone_code = tx_code_r;
   assign tone_single = ctrl_b_r[CB_SINGLE];
   assign tone_column = ctrl_b_r[CB_COLUMN];
   assign interrupt_or_progress_out_n = pin_r;
   assign irq = irq_r;

endmodule : dhs_sequencer

// file: dhs_sequencer_monitor.sv
// bus, flag and interrupt checks for the tone sequencer
`timescale 1ns/1ps
module dhs_sequencer_monitor
   import dhs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // avalon-mm
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // digit and tone side
   input wire logic rx_valid,
   input wire logic tone_on,
   input wire logic irq
);
   localparam int READY_LO = READY_MS * TICK_CYCLES - 2 * TICK_CYCLES;
   localparam int BURST_LO = BURST_MS * TICK_CYCLES - 2 * TICK_CYCLES;
   logic rx_seen_r, rx_seen_nxt;
   logic [31:0] tx_cnt_r, tx_cnt_nxt;
   // saturating age of the last digit write, so late reads cannot wrap
   always_comb
   begin
      rx_seen_nxt = rx_valid | (rx_seen_r & ~(read & ~waitrequest & (address == OFS_STATUS)
         & readdata[ST_RX_FULL]));
      tx_cnt_nxt = (tx_cnt_r == 32'hFFFF_FFFF) ? tx_cnt_r : tx_cnt_r + 32'h0000_0001;
      if (write & ~waitrequest & (address == OFS_TX_DATA))
         tx_cnt_nxt = 32'h0000_0000;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rx_seen_r <= 1'b0;
         tx_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         rx_seen_r <= rx_seen_nxt;
         tx_cnt_r <= tx_cnt_nxt;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_req; (read || write) && waitrequest; endsequence
   sequence s_stat; read && !waitrequest && address == OFS_STATUS; endsequence
   property p_one_wait; s_req |=> !waitrequest; endproperty
   property p_one_pulse; (read || write) && !waitrequest |=> waitrequest; endproperty
   property p_summary; s_stat |-> readdata[0] == (readdata[1] | readdata[2]); endproperty
   property p_rx_full; s_stat ##0 $past(rx_seen_r) |-> readdata[2]; endproperty
   property p_tx_ready; s_stat ##0 readdata[1] |-> tx_cnt_r >= READY_LO; endproperty
   property p_reread; s_stat ##[2:4] s_stat |-> readdata[2:1] == 2'b00; endproperty
   property p_tone_len; $fell(tone_on) |-> tx_cnt_r >= BURST_LO; endproperty
   property p_irq_clear;
      write && !waitrequest && address == OFS_IRQ_CLEAR && writedata[1:0] == 2'b11
         |=> ##1 !irq;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("no answer after one wait cycle");
   a_one_pulse: assert property (p_one_pulse)
      else $error("answer held too long");
   a_summary: assert property (p_summary)
      else $error("summary flag wrong");
   a_rx_full: assert property (p_rx_full)
      else $error("receive flag missing");
   a_tx_ready: assert property (p_tx_ready)
      else $error("ready flag too early");
   a_reread: assert property (p_reread)
      else $error("flags not cleared by read");
   a_tone_len: assert property (p_tone_len)
      else $error("burst too short");
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt not cleared");
endmodule : dhs_sequencer_monitor

// file: dhs_rx_model.sv
// receiver stand-in handing decoded digits to the sequencer
`timescale 1ns/1ps
module dhs_rx_model
(
   // clock
   input wire logic clk,
   // decoded digit handoff
   output logic rx_valid,
   output logic [3:0] rx_code,
   output logic steering_delayed
);
   initial
   begin
      rx_valid = 1'b0;
      rx_code = 4'h0;
      steering_delayed = 1'b1;
   end
   // code goes inverse after the pulse so stale data is never mistaken
   task send(input logic [3:0] c);
      @(posedge clk);
      steering_delayed <= 1'b0;
      repeat (8) @(posedge clk);
      rx_valid <= 1'b1;
      rx_code <= c;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_code <= ~c;
      repeat (8) @(posedge clk);
      steering_delayed <= 1'b1;
   endtask : send
endmodule : dhs_rx_model

// file: dhs_sequencer_test.sv
// self-checking bench for the tone sequencer
`timescale 1ns/1ps
module dhs_sequencer_test
   import dhs_pkg::*;
;
   localparam int TK = 4;
   logic clk, reset, read, write, rx_valid, steering_delayed, progress_tone_in;
   logic waitrequest, tone_on, tone_single, tone_column, pin_n, irq;
   logic [4:0] address;
   logic [3:0] rx_code, tone_code;
   logic [31:0] writedata, readdata, q;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n, t;
   dhs_sequencer #(.TICK_CYCLES(TK)) dut (.clk(clk), .reset(reset), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .rx_valid(rx_valid), .rx_code(rx_code),
      .steering_delayed(steering_delayed), .progress_tone_in(progress_tone_in),
      .tone_on(tone_on), .tone_code(tone_code), .tone_single(tone_single),
      .tone_column(tone_column), .interrupt_or_progress_out_n(pin_n), .irq(irq));
   dhs_rx_model rxm (.clk(clk), .rx_valid(rx_valid), .rx_code(rx_code),
      .steering_delayed(steering_delayed));
   task stop_test;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // one idle cycle after each access keeps every strobe change in its own step
   task bus(input logic we, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      address <= a;
      writedata <= d;
      write <= we;
      read <= ~we;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (waitrequest !== 1'b0 && k < 20);
      q = readdata;
      if (k >= 20)
      begin
         n_mismatch++;
         stop_test();
      end
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask : rd
   task wait_irq(input int lim);
      n = 0;
      t = 0;
      while (irq !== 1'b1)
      begin
         @(posedge clk);
         n++;
         t += int'(tone_on === 1'b1);
         if (n > lim)
         begin
            n_mismatch++;
            stop_test();
         end
      end
   endtask : wait_irq
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      reset = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0000_0000;
      progress_tone_in = 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      repeat (100 * TK) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0008);
      rd(5'h1C, 32'h0000_0000);
      wr(OFS_CONTROL, 32'h0000_000D);
      wr(OFS_CONTROL, 32'h0000_000C);
      wr(OFS_CONTROL, 32'h0000_0005);
      rd(OFS_CONTROL, 32'h0000_00C5);
      chk({30'h0, tone_single, tone_column}, 32'h0000_0003);
      wr(OFS_CONTROL, 32'h0000_000D);
      wr(OFS_CONTROL, 32'h0000_0000);
      rd(OFS_CONTROL, 32'h0000_000D);
      rd(OFS_STATUS, 32'h0000_0008);
      wr(OFS_IRQ_ENABLE, 32'h0000_0003);
      rd(OFS_IRQ_ENABLE, 32'h0000_0003);
      wr(OFS_TX_DATA, 32'h0000_0007);
      wait_irq(1000);
      chk(32'(n inside {[98 * TK:102 * TK]}), 32'h0000_0001);
      chk(32'(t inside {[48 * TK:52 * TK]}), 32'h0000_0001);
      chk({27'h0, tone_code, pin_n}, 32'h0000_000E);
      rd(OFS_STATUS, 32'h0000_000B);
      rd(OFS_STATUS, 32'h0000_0008);
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      wr(OFS_IRQ_CLEAR, 32'h0000_0003);
      rd(OFS_IRQ_STATUS, 32'h0000_0000);
      wr(OFS_TX_DATA, 32'h0000_0005);
      rxm.send(4'h9);
      repeat (102 * TK) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_000F);
      rd(OFS_RX_DATA, 32'h0000_0009);
      rd(OFS_IRQ_STATUS, 32'h0000_0003);
      wr(OFS_IRQ_CLEAR, 32'h0000_0003);
      wr(OFS_CONTROL, 32'h0000_0007);
      wr(OFS_TX_DATA, 32'h0000_0003);
      wait_irq(2000);
      chk(32'(n inside {[196 * TK:204 * TK]}), 32'h0000_0001);
      chk(32'(t inside {[96 * TK:104 * TK]}), 32'h0000_0001);
      chk({31'h0, pin_n}, 32'h0000_0000);
      progress_tone_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, pin_n}, 32'h0000_0001);
      wr(OFS_CONTROL, 32'h0000_0008);
      wr(OFS_CONTROL, 32'h0000_0002);
      @(posedge clk);
      chk({31'h0, pin_n}, 32'h0000_0000);
      wr(OFS_CONTROL, 32'h0000_0009);
      wr(OFS_CONTROL, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_0008);
      chk({31'h0, tone_on}, 32'h0000_0001);
      stop_test();
   end
endmodule : dhs_sequencer_test
bind dhs_sequencer dhs_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clk(clk),
   .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .rx_valid(rx_valid),
   .tone_on(tone_on), .irq(irq));
